/* File: verilog/pe_dev.sv */
// expander end: two-wire slave driving eight push-pull outputs
`timescale 1ns/1ps
`include "pe_map.svh"

// Contract
// - answer only addresses 101 plus pin bits
// - re-decode address pins on every transmission
// - each pin decodes GND, V+, SDA or SCL
// - low strap sets out_port[3:0], high [7:4]
// - high or bus-tied pin gives high default
// - before first transfer pins read as levels
// - reset pin aborts transfer, goes idle
// - reset pin keeps output latch unchanged
// - reads return actual pin levels
// - each written byte updates all outputs together
// - standby whenever the interface is idle
// - master frames start, address, data, stop
// - start: sda falls while scl high
// - stop: sda rises while scl high
// - one bit per clock, stable while high
// - receiver pulls sda low on ninth clock
// - device acks writes, master acks reads
// - device only pulls sda low, scl input
// - master makes every clock and transfer
// - idle bus lines are left released
// - direction bit: low write, high read
// - resample pins at every read acknowledge
// - ack and update each write byte until stop
module pe_dev (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // two-wire bus
   pe_if.dev bus,
   // address straps and bus reset pin
   input wire logic addr_sel_low,
   input wire logic addr_sel_high,
   input wire logic bus_rst_n,
   // output port
   input wire pe_pkg::pe_byte_t out_pin_level,
   output pe_pkg::pe_byte_t out_port,
   output logic standby
);
   import pe_pkg::*;

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [`PE_SYNC_W-1:0] sync1_ff;
   logic [`PE_SYNC_W-1:0] sync2_ff;
   logic scl_d_ff;
   logic sda_d_ff;
   logic rst_n;
   logic pin_hi;
   logic pin_lo;
   logic sda;
   logic scl;
   pe_byte_t pins;

   always_ff @(posedge clk) begin
      if (srst) begin
         sync1_ff <= `PE_SYNC_RST;
         sync2_ff <= `PE_SYNC_RST;
      end else begin
         sync1_ff <= {bus_rst_n, addr_sel_high, addr_sel_low, bus.sda, bus.scl, out_pin_level};
         sync2_ff <= sync1_ff;
      end
   end

   assign {rst_n, pin_hi, pin_lo, sda, scl, pins} = sync2_ff;

   always_ff @(posedge clk) begin
      if (srst) begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_d_ff <= scl;
         sda_d_ff <= sda;
      end
   end

   // ----------------------------------------
   // bus events
   // ----------------------------------------
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;

   assign scl_rise = scl & ~scl_d_ff;
   assign scl_fall = ~scl & scl_d_ff;
   assign start_ev = scl & scl_d_ff & sda_d_ff & ~sda;
   assign stop_ev = scl & scl_d_ff & ~sda_d_ff & sda;

   // ----------------------------------------
   // four-level address decode
   // ----------------------------------------
   // per pin: {seen low, seen high, differs from sda, differs from scl}
   logic [7:0] seen_ff;
   logic [1:0] pin_v;
   logic [6:0] my_addr;
   pe_dev_state_e state_ff;

   function automatic logic [1:0] lvl_dec(input logic [3:0] f);
      if (!f[2]) begin
         lvl_dec = `PE_LVL_GND;
      end else if (!f[3]) begin
         lvl_dec = `PE_LVL_VCC;
      end else if (!f[0]) begin
         lvl_dec = `PE_LVL_SCL;
      end else begin
         lvl_dec = `PE_LVL_SDA;
      end
   endfunction

   assign pin_v = {pin_hi, pin_lo};

   // history restarts at every start, whoever is addressed
   always_ff @(posedge clk) begin
      if (srst || start_ev) begin
         seen_ff <= 8'h00;
      end else if (state_ff == D_ADDR) begin
         for (int g = 0; g < 2; g++) begin
            seen_ff[g*4 +: 4] <= seen_ff[g*4 +: 4] |
               {~pin_v[g], pin_v[g], pin_v[g] ^ sda, pin_v[g] ^ scl};
         end
      end
   end

   // fixed prefix; two bits per four-level pin
   assign my_addr = {`PE_ADDR_FIXED, lvl_dec(seen_ff[7:4]), lvl_dec(seen_ff[3:0])};

   // ----------------------------------------
   // serial protocol engine
   // ----------------------------------------
   logic [3:0] cnt_ff;
   pe_byte_t rx_ff;
   pe_byte_t tx_ff;
   logic rw_ff;
   logic mack_ff;
   logic sda_oe_ff;
   logic sda_o_ff;
   logic wr_byte;

   // the whole byte lands at one edge
   assign wr_byte = (state_ff == D_WDATA) && scl_fall && (cnt_ff == `PE_BIT_ACK);

   always_ff @(posedge clk) begin
      if (srst) begin
         state_ff <= D_IDLE;
         cnt_ff <= 4'h0;
         rx_ff <= 8'h00;
         tx_ff <= 8'h00;
         rw_ff <= 1'b0;
         mack_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
      end else if (!rst_n) begin
         // hung bus recovery: drop the line, back to stopped
         state_ff <= D_IDLE;
         sda_oe_ff <= 1'b0;
      end else if (start_ev) begin
         state_ff <= D_ADDR;
         cnt_ff <= 4'h0;
         sda_oe_ff <= 1'b0;
      end else if (stop_ev) begin
         // release everything when the bus is freed
         state_ff <= D_IDLE;
         sda_oe_ff <= 1'b0;
      end else begin
         // one bit per rising clock edge
         if (scl_rise) begin
            rx_ff <= {rx_ff[6:0], sda};
            cnt_ff <= cnt_ff + 4'h1;
         end
         case (state_ff)
            D_ADDR: begin
               if (scl_fall && cnt_ff == `PE_BIT_ACK) begin
                  // compare against the freshly decoded address
                  if (rx_ff[7:1] == my_addr) begin
                     state_ff <= D_ACK;
                     // pull low through the ninth clock
                     sda_oe_ff <= 1'b1;
                     rw_ff <= rx_ff[0];
                     // pins sampled for the first read byte
                     tx_ff <= pins;
                  end else begin
                     state_ff <= D_WAIT;
                  end
               end
            end
            D_ACK: begin
               if (scl_fall) begin
                  cnt_ff <= 4'h0;
                  if (rw_ff) begin
                     state_ff <= D_RDATA;
                     // a one is sent by releasing the line
                     sda_oe_ff <= ~tx_ff[7];
                  end else begin
                     state_ff <= D_WDATA;
                     sda_oe_ff <= 1'b0;
                  end
               end
            end
            D_WDATA: begin
               if (wr_byte) begin
                  state_ff <= D_ACK;
                  sda_oe_ff <= 1'b1;
               end
            end
            D_RDATA: begin
               if (scl_fall) begin
                  if (cnt_ff == `PE_BIT_ACK) begin
                     state_ff <= D_RACK;
                     sda_oe_ff <= 1'b0;
                  end else begin
                     tx_ff <= {tx_ff[6:0], 1'b0};
                     sda_oe_ff <= ~tx_ff[6];
                  end
               end
            end
            D_RACK: begin
               if (scl_rise) begin
                  mack_ff <= ~sda;
                  tx_ff <= pins;
               end else if (scl_fall) begin
                  cnt_ff <= 4'h0;
                  if (mack_ff) begin
                     state_ff <= D_RDATA;
                     sda_oe_ff <= ~tx_ff[7];
                  end else begin
                     state_ff <= D_WAIT;
                  end
               end
            end
            D_IDLE, D_WAIT: begin
               sda_oe_ff <= 1'b0;
            end
            default: begin
               state_ff <= D_IDLE;
               sda_oe_ff <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // output latch and power-up defaults
   // ----------------------------------------
   logic [1:0] init_cnt_ff;
   pe_byte_t out_ff;

   // straps are caught only once the synchronisers hold real pin levels
   always_ff @(posedge clk) begin
      if (srst) begin
         init_cnt_ff <= 2'h0;
      end else if (init_cnt_ff != 2'h3) begin
         init_cnt_ff <= init_cnt_ff + 2'h1;
      end
   end

   // bus reset pin never touches this latch
   always_ff @(posedge clk) begin
      if (srst) begin
         out_ff <= 8'h00;
      end else if (init_cnt_ff == `PE_INIT_LOAD) begin
         // bus-tied pins read high before any transfer
         out_ff <= {{4{pin_hi}}, {4{pin_lo}}};
      end else if (wr_byte) begin
         out_ff <= rx_ff;
      end
   end

   // ----------------------------------------
   // standby and pin drive
   // ----------------------------------------
   logic standby_ff;

   always_ff @(posedge clk) begin
      if (srst) begin
         standby_ff <= 1'b1;
         sda_o_ff <= 1'b0;
      end else begin
         standby_ff <= (state_ff == D_IDLE);
         sda_o_ff <= 1'b0;
      end
   end

   assign out_port = out_ff;
   assign standby = standby_ff;
   assign bus.dev_sda_o = sda_o_ff;
   assign bus.dev_sda_oe = sda_oe_ff;
endmodule

/* File: verilog/pe_map.svh */
// offsets, field codes, reset values and timing counts of the port expander
`ifndef PE_MAP_SVH
`define PE_MAP_SVH

// fixed upper three bits of the slave address
`define PE_ADDR_FIXED 3'b101

// four-level address pin codes, two address bits per pin
`define PE_LVL_GND 2'h0
`define PE_LVL_VCC 2'h1
`define PE_LVL_SDA 2'h2
`define PE_LVL_SCL 2'h3

// index of the ninth (acknowledge) clock of a byte
`define PE_BIT_ACK 4'h8

// synchroniser reset value: reset pin, straps and bus lines idle high
`define PE_SYNC_W 13
`define PE_SYNC_RST 13'h1_fff

// cycle after srst release at which the straps are taken into the latch
`define PE_INIT_LOAD 2'h2

// bus clock timing, master side
`define PE_CLK_PERIOD_NS 25
`define PE_SCL_PERIOD_NS 2500
`define PE_QTR_CYC ((`PE_SCL_PERIOD_NS / 4) / `PE_CLK_PERIOD_NS)

`endif

/* File: verilog/pe_pkg.sv */
// shared types of the port expander
package pe_pkg;

   typedef enum logic [6:0] {
      D_IDLE  = 7'b000_0001,
      D_ADDR  = 7'b000_0010,
      D_ACK   = 7'b000_0100,
      D_WDATA = 7'b000_1000,
      D_RDATA = 7'b001_0000,
      D_RACK  = 7'b010_0000,
      D_WAIT  = 7'b100_0000
   } pe_dev_state_e;

   typedef enum logic [3:0] {
      H_IDLE  = 4'b0001,
      H_START = 4'b0010,
      H_BIT   = 4'b0100,
      H_STOP  = 4'b1000
   } pe_host_state_e;

   typedef logic [7:0] pe_byte_t;

endpackage

/* File: verilog/pe_if.sv */
// two-wire bus between the master end and the expander end
`timescale 1ns/1ps
interface pe_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;

   // open-drain wired-and with pullups: an undriven line reads high
   assign scl = ~(host_scl_oe & ~host_scl_o);
   assign sda = ~(host_sda_oe & ~host_sda_o) & ~(dev_sda_oe & ~dev_sda_o);

   modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
   modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                 output host_sda_o, output host_sda_oe);
endinterface

/* File: verilog/pe_host.sv */
// master end: frames transfers and makes every bus clock
`timescale 1ns/1ps
`include "pe_map.svh"
module pe_host (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // two-wire bus
   pe_if.host bus,
   // request
   input wire logic req,
   input wire logic req_rw,
   input wire logic [6:0] req_addr,
   input wire logic [3:0] req_nbytes,
   input wire pe_pkg::pe_byte_t req_wdata,
   // answer
   output logic busy,
   output logic done,
   output logic ack_fail,
   output logic wr_take,
   output pe_pkg::pe_byte_t rd_data,
   output logic rd_valid
);
   import pe_pkg::*;

   // ----------------------------------------
   // quarter-bit divider
   // ----------------------------------------
   localparam logic [7:0] QTR_LAST = 8'(`PE_QTR_CYC - 1);
   logic [7:0] qcnt_ff;
   logic tick;
   pe_host_state_e state_ff;

   always_ff @(posedge clk) begin
      if (srst || state_ff == H_IDLE || qcnt_ff == QTR_LAST) begin
         qcnt_ff <= 8'h00;
      end else begin
         qcnt_ff <= qcnt_ff + 8'h01;
      end
   end
   assign tick = (state_ff != H_IDLE) && (qcnt_ff == QTR_LAST);

   // ----------------------------------------
   // transfer sequencer
   // ----------------------------------------
   logic [1:0] ph_ff;
   logic [3:0] bit_ff;
   logic [3:0] left_ff;
   logic rw_ff;
   logic txing_ff;
   pe_byte_t tx_ff;
   pe_byte_t rx_ff;
   logic scl_oe_ff;
   logic sda_oe_ff;
   logic busy_ff;
   logic done_ff;
   logic fail_ff;
   logic take_ff;
   logic rdv_ff;
   pe_byte_t rd_ff;

   always_ff @(posedge clk) begin
      if (srst) begin
         state_ff <= H_IDLE;
         ph_ff <= 2'h0;
         bit_ff <= 4'h0;
         left_ff <= 4'h0;
         rw_ff <= 1'b0;
         txing_ff <= 1'b0;
         tx_ff <= 8'h00;
         rx_ff <= 8'h00;
         scl_oe_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         fail_ff <= 1'b0;
         take_ff <= 1'b0;
         rdv_ff <= 1'b0;
         rd_ff <= 8'h00;
      end else begin
         done_ff <= 1'b0;
         take_ff <= 1'b0;
         rdv_ff <= 1'b0;
         if (state_ff == H_IDLE) begin
            if (req) begin
               state_ff <= H_START;
               ph_ff <= 2'h0;
               rw_ff <= req_rw;
               left_ff <= req_nbytes;
               tx_ff <= {req_addr, req_rw};
               txing_ff <= 1'b1;
               busy_ff <= 1'b1;
               fail_ff <= 1'b0;
            end
         end else if (tick) begin
            ph_ff <= ph_ff + 2'h1;
            case (state_ff)
               H_START: begin
                  // sda falls while scl is high
                  if (ph_ff == 2'h0) begin
                     sda_oe_ff <= 1'b1;
                  end else if (ph_ff == 2'h1) begin
                     scl_oe_ff <= 1'b1;
                     state_ff <= H_BIT;
                     ph_ff <= 2'h0;
                     bit_ff <= 4'h0;
                  end
               end
               H_BIT: begin
                  case (ph_ff)
                     // data changes only while scl is low
                     2'h0: begin
                        if (bit_ff != `PE_BIT_ACK) begin
                           sda_oe_ff <= txing_ff & ~tx_ff[7];
                        end else begin
                           // ack a read byte unless it is the last one
                           sda_oe_ff <= ~txing_ff && (left_ff != 4'h0);
                        end
                     end
                     2'h1: begin
                        scl_oe_ff <= 1'b0;
                     end
                     2'h2: begin
                        if (bit_ff != `PE_BIT_ACK) begin
                           tx_ff <= {tx_ff[6:0], 1'b0};
                           rx_ff <= {rx_ff[6:0], bus.sda};
                        end else if (txing_ff && bus.sda) begin
                           fail_ff <= 1'b1;
                        end
                     end
                     default: begin
                        scl_oe_ff <= 1'b1;
                        if (bit_ff != `PE_BIT_ACK) begin
                           bit_ff <= bit_ff + 4'h1;
                        end else begin
                           bit_ff <= 4'h0;
                           if (!txing_ff) begin
                              rdv_ff <= 1'b1;
                              rd_ff <= rx_ff;
                           end
                           if (fail_ff || left_ff == 4'h0) begin
                              state_ff <= H_STOP;
                           end else begin
                              left_ff <= left_ff - 4'h1;
                              txing_ff <= ~rw_ff;
                              if (!rw_ff) begin
                                 tx_ff <= req_wdata;
                                 take_ff <= 1'b1;
                              end
                           end
                        end
                     end
                  endcase
               end
               H_STOP: begin
                  // sda rises while scl is high
                  case (ph_ff)
                     2'h0: sda_oe_ff <= 1'b1;
                     2'h1: scl_oe_ff <= 1'b0;
                     2'h2: sda_oe_ff <= 1'b0;
                     default: begin
                        state_ff <= H_IDLE;
                        busy_ff <= 1'b0;
                        done_ff <= 1'b1;
                     end
                  endcase
               end
               default: begin
                  state_ff <= H_IDLE;
                  scl_oe_ff <= 1'b0;
                  sda_oe_ff <= 1'b0;
               end
            endcase
         end
      end
   end

   // open-drain: the driven value is always low
   logic zero_ff;
   always_ff @(posedge clk) begin
      zero_ff <= 1'b0;
   end

   assign bus.host_scl_o = zero_ff;
   assign bus.host_sda_o = zero_ff;
   assign bus.host_scl_oe = scl_oe_ff;
   assign bus.host_sda_oe = sda_oe_ff;
   assign busy = busy_ff;
   assign done = done_ff;
   assign ack_fail = fail_ff;
   assign wr_take = take_ff;
   assign rd_data = rd_ff;
   assign rd_valid = rdv_ff;
endmodule

/* File: tb/pe_link_asserts.sv */
// concurrent checks on the two-wire link between master end and expander end
`timescale 1ns/1ps
module pe_link_asserts (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // link signals
   input wire logic host_scl_o,
   input wire logic host_scl_oe,
   input wire logic host_sda_o,
   input wire logic host_sda_oe,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   // ------------------------------------------------------------
   // helper: length of the current device pull, saturating
   // ------------------------------------------------------------
   logic [7:0] pull_cnt_ff;

   always_ff @(posedge clk) begin
      if (srst || !dev_sda_oe) begin
         pull_cnt_ff <= 8'h00;
      end else if (pull_cnt_ff != 8'hff) begin
         pull_cnt_ff <= pull_cnt_ff + 8'h01;
      end
   end

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   property p_dev_od;
      dev_sda_o == 1'b0;
   endproperty
   a_dev_od: assert property (p_dev_od) else $error("device drives sda high");

   property p_host_od;
      host_scl_o == 1'b0 && host_sda_o == 1'b0;
   endproperty
   a_host_od: assert property (p_host_od) else $error("master drives a line high");

   property p_rst_idle;
      $fell(srst) |-> !dev_sda_oe && !host_sda_oe && !host_scl_oe;
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("lines held after reset");

   property p_start;
      $rose(host_sda_oe) && !host_scl_oe |-> ##[20:30] host_scl_oe;
   endproperty
   a_start: assert property (p_start) else $error("no clock after start");

   property p_stop;
      $fell(host_sda_oe) && !host_scl_oe |=> !host_scl_oe [*8];
   endproperty
   a_stop: assert property (p_stop) else $error("clock moved after stop");

   property p_stop_free;
      $fell(host_sda_oe) && !host_scl_oe |-> ##[1:10] sda;
   endproperty
   a_stop_free: assert property (p_stop_free) else $error("sda held after stop");

   property p_pull_scl_low;
      $rose(dev_sda_oe) |-> !scl;
   endproperty
   a_pull_scl_low: assert property (p_pull_scl_low) else $error("device pull with scl high");

   property p_pull_hold;
      $fell(dev_sda_oe) |-> pull_cnt_ff >= 8'h5a;
   endproperty
   a_pull_hold: assert property (p_pull_hold) else $error("device pull too short");

   property p_scl_low;
      $rose(host_scl_oe) |=> host_scl_oe [*8];
   endproperty
   a_scl_low: assert property (p_scl_low) else $error("clock low phase too short");

   c_start: cover property ($rose(host_sda_oe) && !host_scl_oe);
   c_dev_pull: cover property ($rose(dev_sda_oe));
   c_stop: cover property ($fell(host_sda_oe) && !host_scl_oe);
endmodule

/* File: tb/i2c_push_pull_output_expander_tb.sv */
// self-checking bench joining the master end and the expander end
`timescale 1ns/1ps
`include "pe_map.svh"
module i2c_push_pull_output_expander_tb;
   import pe_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic req = 1'b0;
   logic req_rw = 1'b0;
   logic [6:0] req_addr = 7'h00;
   logic [3:0] req_nbytes = 4'h1;
   pe_byte_t req_wdata = 8'h00;
   logic bus_rst_n = 1'b1;
   logic [1:0] lo_code = `PE_LVL_GND;
   logic [1:0] hi_code = `PE_LVL_VCC;
   logic pin_ovr = 1'b0;
   pe_byte_t pin_val = 8'h00;
   logic addr_sel_low, addr_sel_high, standby, busy, done, ack_fail, wr_take, rd_valid;
   pe_byte_t out_pin_level, out_port, rd_data;
   pe_byte_t rd_q [2];
   int n_errors = 0;
   int total_checks = 0;
   int cyc = 0;

   pe_if bus ();

   // straps may sit on a bus line, so they follow the live wires
   function automatic logic strap(input logic [1:0] code, input logic sda, input logic scl);
      case (code)
         `PE_LVL_GND: strap = 1'b0;
         `PE_LVL_VCC: strap = 1'b1;
         `PE_LVL_SDA: strap = sda;
         default: strap = scl;
      endcase
   endfunction
   assign addr_sel_low = strap(lo_code, bus.sda, bus.scl);
   assign addr_sel_high = strap(hi_code, bus.sda, bus.scl);
   assign out_pin_level = pin_ovr ? pin_val : out_port;

   pe_dev i_pe_dev (.clk(clk), .srst(srst), .bus(bus), .addr_sel_low(addr_sel_low),
      .addr_sel_high(addr_sel_high), .bus_rst_n(bus_rst_n), .out_pin_level(out_pin_level),
      .out_port(out_port), .standby(standby));
   pe_host i_pe_host (.clk(clk), .srst(srst), .bus(bus), .req(req), .req_rw(req_rw),
      .req_addr(req_addr), .req_nbytes(req_nbytes), .req_wdata(req_wdata), .busy(busy),
      .done(done), .ack_fail(ack_fail), .wr_take(wr_take), .rd_data(rd_data),
      .rd_valid(rd_valid));
   pe_link_asserts i_pe_link_asserts (.clk(clk), .srst(srst), .host_scl_o(bus.host_scl_o),
      .host_scl_oe(bus.host_scl_oe), .host_sda_o(bus.host_sda_o),
      .host_sda_oe(bus.host_sda_oe), .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe),
      .scl(bus.scl), .sda(bus.sda));

   // ------------------------------------------------------------
   // clock, timeout and common tasks
   // ------------------------------------------------------------
   initial begin
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         n_errors++;
         $display("FAIL %0t run hung", $time);
         final_report;
      end
   end

   task automatic final_report;
      if (n_errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk_byte(input pe_byte_t got, input pe_byte_t exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %0t %s got %h want %h", $time, msg, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %0t %s", $time, msg);
      end
   endtask

   task automatic do_reset;
      srst <= 1'b1;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      repeat (6) @(posedge clk);
   endtask

   // one master transfer; the second byte is presented once the first is taken
   task automatic xfer(input logic rw, input logic [6:0] a, input logic [3:0] n,
                       input pe_byte_t b0, input pe_byte_t b1);
      int nr;
      nr = 0;
      rd_q[0] = 8'hxx;
      rd_q[1] = 8'hxx;
      @(posedge clk);
      req <= 1'b1;
      req_rw <= rw;
      req_addr <= a;
      req_nbytes <= n;
      req_wdata <= b0;
      @(posedge clk);
      req <= 1'b0;
      for (int k = 0; k < 4000 && done !== 1'b1; k++) begin
         @(posedge clk);
         if (k == 0) chk_bit(busy, 1'b1, "request not taken");
         if (wr_take === 1'b1) req_wdata <= b1;
         if (rd_valid === 1'b1 && nr < 2) begin
            rd_q[nr] = rd_data;
            nr++;
         end
      end
      chk_bit(done, 1'b1, "transfer never finished");
      chk_bit(busy, 1'b0, "busy after stop");
      chk_bit(bus.scl & bus.sda, 1'b1, "lines held after stop");
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // strap power-up levels
   task automatic t_powerup;
      lo_code <= `PE_LVL_SDA;
      hi_code <= `PE_LVL_GND;
      do_reset;
      chk_byte(out_port, 8'h0f, "bus-tied default");
      chk_bit(standby, 1'b1, "idle without standby");
      lo_code <= `PE_LVL_GND;
      hi_code <= `PE_LVL_VCC;
      do_reset;
      chk_byte(out_port, 8'hf0, "strap default");
   endtask

   task automatic t_addr_map;
      pe_byte_t d;
      for (int h = 0; h < 4; h++) begin
         for (int l = 0; l < 4; l++) begin
            lo_code <= 2'(l);
            hi_code <= 2'(h);
            d = {2'h2, 2'(h), 2'(l), 2'h1};
            xfer(1'b0, {`PE_ADDR_FIXED, 2'(h), 2'(l)}, 4'h1, d, d);
            chk_bit(ack_fail, 1'b0, "own address unanswered");
            chk_byte(out_port, d, "write not applied");
         end
      end
      lo_code <= `PE_LVL_GND;
      hi_code <= `PE_LVL_VCC;
   endtask

   task automatic t_wrong_addr;
      xfer(1'b0, 7'h64, 4'h1, 8'h00, 8'h00);
      chk_bit(ack_fail, 1'b1, "foreign prefix answered");
      xfer(1'b0, 7'h55, 4'h1, 8'h00, 8'h00);
      chk_bit(ack_fail, 1'b1, "foreign low bits answered");
      chk_byte(out_port, 8'hbd, "latch moved");
   endtask

   task automatic t_write2;
      fork
         xfer(1'b0, 7'h54, 4'h2, 8'ha5, 8'h3c);
         begin
            repeat (2000) @(posedge clk);
            chk_byte(out_port, 8'ha5, "first byte not applied");
            chk_bit(standby, 1'b0, "standby in transfer");
         end
      join
      chk_byte(out_port, 8'h3c, "second byte not applied");
      chk_bit(ack_fail, 1'b0, "write bytes unanswered");
   endtask

   task automatic t_read2;
      pin_ovr <= 1'b1;
      pin_val <= 8'h96;
      fork
         xfer(1'b1, 7'h54, 4'h2, 8'h00, 8'h00);
         begin
            repeat (1300) @(posedge clk);
            pin_val <= 8'h69;
         end
      join
      chk_byte(rd_q[0], 8'h96, "first read byte");
      chk_byte(rd_q[1], 8'h69, "second read byte");
      chk_byte(out_port, 8'h3c, "read moved latch");
      chk_bit(ack_fail, 1'b0, "read address unanswered");
      pin_ovr <= 1'b0;
   endtask

   task automatic t_bus_rst;
      fork
         xfer(1'b0, 7'h54, 4'h2, 8'h11, 8'h22);
         begin
            repeat (500) @(posedge clk);
            bus_rst_n <= 1'b0;
            repeat (20) @(posedge clk);
            chk_bit(standby, 1'b1, "bus reset left interface busy");
            chk_byte(out_port, 8'h3c, "bus reset moved latch");
            bus_rst_n <= 1'b1;
         end
      join
      chk_bit(ack_fail, 1'b1, "aborted transfer answered");
      chk_byte(out_port, 8'h3c, "aborted transfer moved latch");
      xfer(1'b0, 7'h54, 4'h1, 8'h5a, 8'h5a);
      chk_byte(out_port, 8'h5a, "no recovery after bus reset");
   endtask

   initial begin
      do_reset;
      t_powerup;
      t_addr_map;
      t_wrong_addr;
      t_write2;
      t_read2;
      t_bus_rst;
      final_report;
   end
endmodule
